// >>> rtl/kwi_pkg.sv
package kwi_pkg;
	// ********************************
	// Register map
	// ********************************
	localparam int KWI_ADDR_W = 8;
	localparam logic [7:0] KWI_MASK_OFS = 8'h86;
	localparam logic [7:0] KWI_AUX_OFS = 8'ha2;
	localparam logic [7:0] KWI_IRQ_STAT_OFS = 8'ha8;
	localparam logic [7:0] KWI_IRQ_MASK_OFS = 8'ha9;
	localparam logic [7:0] KWI_WAKE_OFS = 8'haa;
	// ********************************
	// Field positions and reset values
	// ********************************
	localparam int KWI_FLAG_BIT = 1;
	localparam int KWI_IEN_BIT = 7;
	localparam int KWI_PRIO_LSB = 0;
	localparam logic [7:0] KWI_MASK_RST = 8'h00;
	localparam logic [1:0] KWI_PRIO_RST = 2'h0;
	localparam int KWI_EV_FLAG = 0;
	localparam int KWI_EV_WAKE = 1;
	localparam int KWI_SYNC_STAGES = 2;
	typedef enum logic [1:0] {KWI_RUN, KWI_IDLE, KWI_PDOWN} kwi_pwr_t;
endpackage

// >>> rtl/kwi_sync.sv
`timescale 1ns/10ps
module kwi_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync
);
	import kwi_pkg::*;
	typedef struct packed
	{
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} kwi_sync_st_t;
	kwi_sync_st_t s_q;
	kwi_sync_st_t s_d;
	always_comb
	begin
		s_d.meta = pin_in;
		s_d.sync = s_q.meta;
	end
	// Idle level high so reset never fakes a key press
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			s_q <= '1;
		else
			s_q <= s_d;
	end
	assign pin_sync = s_q.sync;
endmodule

// >>> rtl/kwi_detect.sv
`timescale 1ns/10ps
module kwi_detect #(
	parameter int WIDTH = 8
) (
	// Pins and selection
	input wire logic [WIDTH-1:0] pin_sync,
	input wire logic [WIDTH-1:0] pin_mask,
	// Result
	output logic any_low
);
	logic [WIDTH-1:0] hit;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_pin
			// Any subset may be selected, from none to all
			assign hit[i] = pin_mask[i] & ~pin_sync[i];
		end
	endgenerate
	assign any_low = |hit;
endmodule

// >>> rtl/kwi_top.sv
`timescale 1ns/10ps
// Operation
// - Mask bit n set makes port pin n a keypad interrupt source.
// - Any combination of the eight pins, none to all, may be selected.
// - Flag sets whenever a selected pin is low while function active.
// - Flag raises interrupt request only when keypad interrupt enabled.
// - Flag stays set until software clears it; never cleared on entry.
// - Enabled keypad interrupt wakes the core from idle and power down.
// - Mask has no effect while the keypad interrupt enable is clear.
// - Power down wake needs enable and priority above current service.
module kwi_top #(
	parameter int NPINS = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic [kwi_pkg::KWI_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Keypad pins
	input wire logic [NPINS-1:0] keypad_input_port,
	// Core power state and service level
	input wire kwi_pkg::kwi_pwr_t pwr_mode,
	input wire logic [1:0] active_prio,
	input wire logic in_service,
	// Outputs
	output logic kp_irq_req,
	output logic wake_req,
	output logic irq
);
	import kwi_pkg::*;

	// ********************************
	// State
	// ********************************
	typedef struct packed
	{
		logic [7:0] keypad_pin_enable_mask;
		logic keypad_event_flag;
		logic kp_ien;
		logic [1:0] kp_prio;
		logic [1:0] stat;
		logic [1:0] imask;
		logic wake;
		logic [7:0] rdata;
	} kwi_state_t;
	kwi_state_t s_q;
	kwi_state_t s_d;

	logic [NPINS-1:0] pin_sync;
	logic [7:0] mask_eff;
	logic any_low;
	logic flag_set;
	logic req;
	logic wake_now;
	logic sleeping;

	// ********************************
	// Pin path
	// ********************************
	kwi_sync #(.WIDTH(NPINS)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin_in(keypad_input_port),
		.pin_sync(pin_sync)
	);

	// Mask is only effective while the keypad interrupt is enabled
	assign mask_eff = s_q.kp_ien ? s_q.keypad_pin_enable_mask : 8'h00;

	kwi_detect #(.WIDTH(NPINS)) u_det (
		.pin_sync(pin_sync),
		.pin_mask(mask_eff[NPINS-1:0]),
		.any_low(any_low)
	);

	assign flag_set = any_low;
	assign req = s_q.keypad_event_flag & s_q.kp_ien;
	assign sleeping = (pwr_mode == KWI_IDLE) || (pwr_mode == KWI_PDOWN);

	// Power down additionally requires the priority to beat any live service
	always_comb
	begin
		wake_now = 1'b0;
		unique case (pwr_mode)
			KWI_RUN: wake_now = 1'b0;
			KWI_IDLE: wake_now = req;
			KWI_PDOWN: wake_now = req && (!in_service || s_q.kp_prio > active_prio);
			default: wake_now = 1'b0;
		endcase
	end

	// ********************************
	// Next state
	// ********************************
	always_comb
	begin
		s_d = s_q;
		s_d.rdata = 8'h00;
		s_d.wake = wake_now;
		if (reg_wr)
		begin
			unique case (reg_addr)
				KWI_MASK_OFS: s_d.keypad_pin_enable_mask = reg_wdata;
				KWI_AUX_OFS:
				begin
					s_d.keypad_event_flag = reg_wdata[KWI_FLAG_BIT];
					s_d.kp_ien = reg_wdata[KWI_IEN_BIT];
				end
				KWI_IRQ_STAT_OFS: s_d.stat = s_q.stat & ~reg_wdata[1:0];
				KWI_IRQ_MASK_OFS: s_d.imask = reg_wdata[1:0];
				KWI_WAKE_OFS: s_d.kp_prio = reg_wdata[KWI_PRIO_LSB +: 2];
				default: s_d = s_d;
			endcase
		end
		// Set wins over a software clear; a held key re-sets the flag
		if (flag_set)
			s_d.keypad_event_flag = 1'b1;
		if (flag_set)
			s_d.stat[KWI_EV_FLAG] = 1'b1;
		if (wake_now && !s_q.wake)
			s_d.stat[KWI_EV_WAKE] = 1'b1;
		if (reg_rd)
		begin
			unique case (reg_addr)
				KWI_MASK_OFS: s_d.rdata = s_q.keypad_pin_enable_mask;
				KWI_AUX_OFS:
				begin
					s_d.rdata[KWI_FLAG_BIT] = s_q.keypad_event_flag;
					s_d.rdata[KWI_IEN_BIT] = s_q.kp_ien;
				end
				KWI_IRQ_STAT_OFS: s_d.rdata = {6'h00, s_q.stat};
				KWI_IRQ_MASK_OFS: s_d.rdata = {6'h00, s_q.imask};
				KWI_WAKE_OFS: s_d.rdata = {5'h00, sleeping, s_q.kp_prio};
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.keypad_pin_enable_mask <= KWI_MASK_RST;
			s_q.kp_prio <= KWI_PRIO_RST;
		end
		else
			s_q <= s_d;
	end

	assign reg_rdata = s_q.rdata;
	assign kp_irq_req = req;
	assign wake_req = wake_now;
	assign irq = |(s_q.stat & s_q.imask);

	// ********************************
	// Checks: pin path and event flag
	// ********************************
	pin_select_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.kp_ien && |(s_q.keypad_pin_enable_mask[NPINS-1:0] & ~pin_sync)
		|-> any_low)
		else $error("selected low pin missed");

	select_only_a: assert property (@(posedge ref_clk) disable iff (rst)
		any_low
		|-> s_q.kp_ien && |(s_q.keypad_pin_enable_mask[NPINS-1:0] & ~pin_sync))
		else $error("event from an unselected pin");

	none_selected_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.keypad_pin_enable_mask == 8'h00
		|-> !any_low)
		else $error("unselected pin raised event");

	mask_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		!s_q.kp_ien
		|-> !any_low)
		else $error("mask effective while disabled");

	sync_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(keypad_input_port[0])
		|=> pin_sync[0] ##1 !pin_sync[0])
		else $error("pin synchroniser delay wrong");

	resample_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(keypad_input_port[NPINS-1]) ##1 (!keypad_input_port[NPINS-1] && !reg_wr
		&& s_q.kp_ien && s_q.keypad_pin_enable_mask[NPINS-1])
		|-> ##2 s_q.keypad_event_flag)
		else $error("synchronised low not caught");

	flag_sets_a: assert property (@(posedge ref_clk) disable iff (rst)
		any_low
		|=> s_q.keypad_event_flag)
		else $error("flag not set after selected pin low");

	flag_only_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
		!s_q.keypad_event_flag && !any_low && !(reg_wr && reg_addr == KWI_AUX_OFS)
		|=> !s_q.keypad_event_flag)
		else $error("flag set with no selected low pin");

	flag_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.keypad_event_flag && !(reg_wr && reg_addr == KWI_AUX_OFS)
		|=> s_q.keypad_event_flag)
		else $error("flag cleared without software");

	flag_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == KWI_AUX_OFS && !reg_wdata[KWI_FLAG_BIT] && !any_low
		|=> !s_q.keypad_event_flag)
		else $error("software clear of flag lost");

	flag_write_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == KWI_AUX_OFS && reg_wdata[KWI_FLAG_BIT]
		|=> s_q.keypad_event_flag)
		else $error("software set of flag lost");

	set_beats_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		any_low && reg_wr && reg_addr == KWI_AUX_OFS
		|=> s_q.keypad_event_flag)
		else $error("clear beat a held key");

	// ********************************
	// Checks: register port
	// ********************************
	reset_values_a: assert property (@(posedge ref_clk)
		rst
		|=> s_q.keypad_pin_enable_mask == KWI_MASK_RST && s_q.kp_prio == KWI_PRIO_RST)
		else $error("register not at reset value");

	reset_outputs_a: assert property (@(posedge ref_clk)
		rst
		|=> !kp_irq_req && !wake_req && !irq && reg_rdata == 8'h00)
		else $error("output active after reset");

	mask_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == KWI_MASK_OFS
		|=> s_q.keypad_pin_enable_mask == $past(reg_wdata))
		else $error("pin enable mask write lost");

	mask_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(reg_wr && reg_addr == KWI_MASK_OFS)
		|=> $stable(s_q.keypad_pin_enable_mask))
		else $error("pin enable mask changed unasked");

	ien_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == KWI_AUX_OFS
		|=> s_q.kp_ien == $past(reg_wdata[KWI_IEN_BIT]))
		else $error("keypad interrupt enable write lost");

	prio_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == KWI_WAKE_OFS
		|=> s_q.kp_prio == $past(reg_wdata[KWI_PRIO_LSB +: 2]))
		else $error("wake priority write lost");

	mask_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == KWI_MASK_OFS
		|=> reg_rdata == $past(s_q.keypad_pin_enable_mask))
		else $error("pin enable mask read wrong");

	flag_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == KWI_AUX_OFS
		|=> reg_rdata[KWI_FLAG_BIT] == $past(s_q.keypad_event_flag))
		else $error("flag read wrong");

	rdata_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		!reg_rd
		|=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");

	// ********************************
	// Checks: status and interrupt
	// ********************************
	req_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == KWI_AUX_OFS && !reg_wdata[KWI_IEN_BIT]
		|=> !kp_irq_req)
		else $error("request without enable");

	stat_flag_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		any_low
		|=> s_q.stat[KWI_EV_FLAG])
		else $error("flag event not in status");

	stat_w1c_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == KWI_IRQ_STAT_OFS && reg_wdata[KWI_EV_FLAG] && !any_low
		|=> !s_q.stat[KWI_EV_FLAG])
		else $error("status flag event not cleared");

	stat_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.stat[KWI_EV_FLAG] && !(reg_wr && reg_addr == KWI_IRQ_STAT_OFS)
		|=> s_q.stat[KWI_EV_FLAG])
		else $error("status flag event lost");

	wake_stat_a: assert property (@(posedge ref_clk) disable iff (rst)
		wake_req && !s_q.wake
		|=> s_q.stat[KWI_EV_WAKE])
		else $error("wake event not in status");

	wake_stat_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.stat[KWI_EV_WAKE] && !(reg_wr && reg_addr == KWI_IRQ_STAT_OFS)
		|=> s_q.stat[KWI_EV_WAKE])
		else $error("status wake event lost");

	irq_level_a: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == KWI_IRQ_MASK_OFS && reg_wdata[1:0] == 2'h0
		|=> !irq)
		else $error("interrupt with all sources masked");

	irq_unmasked_a: assert property (@(posedge ref_clk) disable iff (rst)
		any_low && s_q.imask[KWI_EV_FLAG] && !(reg_wr && reg_addr == KWI_IRQ_MASK_OFS)
		|=> irq)
		else $error("unmasked flag event gave no interrupt");

	// ********************************
	// Checks: wake-up
	// ********************************
	idle_wake_a: assert property (@(posedge ref_clk) disable iff (rst)
		pwr_mode == KWI_IDLE && kp_irq_req
		|-> wake_req)
		else $error("idle wake missing");

	run_no_wake_a: assert property (@(posedge ref_clk) disable iff (rst)
		pwr_mode == KWI_RUN
		|-> !wake_req)
		else $error("wake request while running");

	no_req_no_wake_a: assert property (@(posedge ref_clk) disable iff (rst)
		!kp_irq_req
		|-> !wake_req)
		else $error("wake without an enabled request");

	pdown_prio_a: assert property (@(posedge ref_clk) disable iff (rst)
		pwr_mode == KWI_PDOWN && in_service && s_q.kp_prio <= active_prio
		|-> !wake_req)
		else $error("power down wake with low priority");

	pdown_free_a: assert property (@(posedge ref_clk) disable iff (rst)
		pwr_mode == KWI_PDOWN && kp_irq_req && !in_service
		|-> wake_req)
		else $error("power down wake missing");

	pdown_high_a: assert property (@(posedge ref_clk) disable iff (rst)
		pwr_mode == KWI_PDOWN && kp_irq_req && s_q.kp_prio > active_prio
		|-> wake_req)
		else $error("power down wake with high priority missing");

endmodule

// >>> testbench/kwi_keypad.sv
`timescale 1ns/10ps
module kwi_keypad (
	// Keys held down
	input wire logic [7:0] key_down,
	// Port pins, pulled up while no key closes
	output logic [7:0] pins
);
	// A closed key shorts its pin low; a released pin floats up to its pull-up
	assign pins = ~key_down;
endmodule

// >>> testbench/keypad_wake_interrupt_bench.sv
`timescale 1ns/10ps
module keypad_wake_interrupt_bench;
	import kwi_pkg::*;
	logic ref_clk, rst, reg_wr, reg_rd, in_service, kp_irq_req, wake_req, irq;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, key_down, pins;
	logic [1:0] active_prio;
	kwi_pwr_t pwr_mode;
	int error_cnt;
	int n_checks;
	kwi_top i_kwi_top (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.keypad_input_port(pins), .pwr_mode(pwr_mode), .active_prio(active_prio),
		.in_service(in_service), .kp_irq_req(kp_irq_req), .wake_req(wake_req), .irq(irq));
	kwi_keypad i_kwi_keypad (.key_down(key_down), .pins(pins));
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// ********************************
	// Register port and pin drivers
	// ********************************
	// Every task but report_and_stop ends 1 ns past an edge, so outputs have settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, reg_rdata, exp);
	endtask
	// Two sync stages plus the flag edge fit in four cycles
	task automatic press(input logic [7:0] k);
		@(posedge ref_clk);
		key_down <= k;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
	task automatic core(input kwi_pwr_t m, input logic srv, input logic [1:0] p);
		@(posedge ref_clk);
		pwr_mode <= m;
		in_service <= srv;
		active_prio <= p;
		#1;
	endtask
	task report_and_stop;
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#400000;
		error_cnt++;
		report_and_stop;
	end
	// ********************************
	// Tests
	// ********************************
	initial
	begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		key_down = 8'h00;
		pwr_mode = KWI_RUN;
		in_service = 1'b0;
		active_prio = 2'h0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		rd(KWI_MASK_OFS, KWI_MASK_RST, "mask reset");
		rd(KWI_AUX_OFS, 8'h00, "aux reset");
		rd(8'h00, 8'h00, "unmapped read");
		wr(KWI_MASK_OFS, 8'ha5);
		rd(KWI_MASK_OFS, 8'ha5, "mask rw");
		press(8'h01);
		rd(KWI_AUX_OFS, 8'h00, "flag enable off");
		press(8'h00);
		wr(KWI_AUX_OFS, 8'h80);
		press(8'h5a);
		rd(KWI_AUX_OFS, 8'h80, "unselected pins");
		press(8'h04);
		rd(KWI_AUX_OFS, 8'h82, "flag set");
		chk("kp_irq_req on", kp_irq_req, 8'h01);
		press(8'h00);
		rd(KWI_AUX_OFS, 8'h82, "flag sticky");
		rd(KWI_IRQ_STAT_OFS, 8'h01, "status flag");
		chk("irq masked", irq, 8'h00);
		wr(KWI_IRQ_MASK_OFS, 8'h01);
		chk("irq unmasked", irq, 8'h01);
		core(KWI_IDLE, 1'b0, 2'h0);
		chk("wake idle", wake_req, 8'h01);
		core(KWI_PDOWN, 1'b1, 2'h3);
		chk("wake prio low", wake_req, 8'h00);
		wr(KWI_WAKE_OFS, 8'h02);
		core(KWI_PDOWN, 1'b1, 2'h1);
		chk("wake prio high", wake_req, 8'h01);
		rd(KWI_WAKE_OFS, 8'h06, "wake reg sleeping");
		core(KWI_RUN, 1'b0, 2'h0);
		rd(KWI_IRQ_STAT_OFS, 8'h03, "status wake");
		press(8'h80);
		wr(KWI_AUX_OFS, 8'h80);
		rd(KWI_AUX_OFS, 8'h82, "flag re-set");
		press(8'h00);
		wr(KWI_AUX_OFS, 8'h80);
		rd(KWI_AUX_OFS, 8'h80, "flag cleared");
		chk("kp_irq_req off", kp_irq_req, 8'h00);
		wr(KWI_IRQ_STAT_OFS, 8'h03);
		rd(KWI_IRQ_STAT_OFS, 8'h00, "status w1c");
		chk("irq cleared", irq, 8'h00);
		wr(KWI_AUX_OFS, 8'h02);
		chk("flag no enable", kp_irq_req, 8'h00);
		report_and_stop;
	end
endmodule
